// ### hdl/status_special_pkg.sv
/*
  Constants, field layouts and carrier types for the status and special
  register write unit. Assumes a core that numbers instruction and
  register bits big-endian, with bit 0 as the most significant bit.
*/
// How it works
// [RULE1] Set-status-bit op (63/38) forces the indexed status bit to one.
// [RULE2] Set-status-bit never sets bits 1 and 2 directly; they stay derived.
// [RULE3] Set-status-bit may also raise the exception summary bit.
// [RULE4] Record forms load condition field one from status bits 0 to 3.
// [RULE5] Masked write (711) copies each selected nibble of the low source word.
// [RULE6] Masked write leaves the exception summary alone unless mask bit 0 is set.
// [RULE7] Field 0 write takes summary and overflow straight from source bits.
// [RULE8] Field 0 write derives enabled and invalid summaries, ignoring source.
// [RULE9] Immediate form writes its nibble into the field its index selects.
// [RULE10] Machine state write copies the whole source, supervisor only.
// [RULE11] Machine state write synchronizes unless only doze or byte order change.
// [RULE12] Interrupt enable takes effect at completion; pending interrupt then taken.
// [RULE13] Special register number is bits 16-20 high, bits 11-15 low.
// [RULE14] User level accepts numbers 1, 8 and 9: exception, link, count.
// [RULE15] Undefined number in user mode traps or is boundedly undefined.
// [RULE16] User-access numbers place the source value in the register.
// [RULE17] Time base halves are written independently of each other.
// [RULE18] Supervisor-only register written in user state raises privileged fault.
// [RULE19] User state, undefined number with privileged bit: only a fault.
// [RULE20] Other undefined numbers raise illegal fault or are boundedly undefined.
// [RULE21] Condition field one uses status bits after this op's own update.
package status_special_pkg;

  // ------------------------------------------------------------
  // Opcodes
  // ------------------------------------------------------------
  localparam logic [0:5] OP_FP = 6'h3f;
  localparam logic [0:5] OP_INT = 6'h1f;
  localparam logic [0:9] XO_SET_BIT = 10'h026;
  localparam logic [0:9] XO_FIELDS = 10'h2c7;
  localparam logic [0:9] XO_FIELD_IMM = 10'h086;
  localparam logic [0:9] XO_MSR = 10'h092;
  localparam logic [0:9] XO_SPR = 10'h1d3;

  // ------------------------------------------------------------
  // Status word layout
  // ------------------------------------------------------------
  localparam int NIB = 4;
  localparam int NFIELD = 8;
  localparam int FX = 0;
  localparam int FP_ENABLED_SUMMARY = 1;
  localparam int VX = 2;
  localparam int OX = 3;
  localparam int EXC_LO = 3;
  localparam int EXC_HI = 12;
  localparam int VXB_LO = 7;
  localparam int VXB_HI = 12;
  localparam int VXE_LO = 21;
  localparam int VXE_HI = 23;
  localparam int EXB_LO = 2;
  localparam int EXB_HI = 6;
  localparam int ENB_LO = 24;
  localparam int ENB_HI = 28;

  // ------------------------------------------------------------
  // Machine state word layout
  // ------------------------------------------------------------
  localparam int MSR_EE = 16;
  localparam int MSR_PR = 17;
  // Doze request (bit 13) and byte order (bit 31) need no synchronization.
  localparam logic [0:31] SYNC_FREE = 32'h0004_0001;

  // ------------------------------------------------------------
  // Special register numbers
  // ------------------------------------------------------------
  localparam logic [0:9] SPR_XER = 10'h001;
  localparam logic [0:9] SPR_LR = 10'h008;
  localparam logic [0:9] SPR_CTR = 10'h009;
  localparam logic [0:9] SPR_TBL = 10'h11c;
  localparam logic [0:9] SPR_TBU = 10'h11d;

  // ------------------------------------------------------------
  // Reset values and bus map
  // ------------------------------------------------------------
  localparam logic [0:31] FLOAT_STATUS_CONTROL_RST = 32'h0000_0000;
  localparam logic [0:31] MSR_RST = 32'h0000_0000;
  localparam logic [0:31] WORD_RST = 32'h0000_0000;
  localparam logic [63:0] TB_RST = 64'h0;
  localparam logic [63:0] TB_ONE = 64'h1;
  localparam int AW = 8;
  localparam logic [AW-1:0] A_FLOAT_STATUS_CONTROL = 8'h00;
  localparam logic [AW-1:0] A_MSR = 8'h04;
  localparam logic [AW-1:0] A_CR1 = 8'h08;
  localparam logic [AW-1:0] A_XER = 8'h0c;
  localparam logic [AW-1:0] A_LR = 8'h10;
  localparam logic [AW-1:0] A_CTR = 8'h14;
  localparam logic [AW-1:0] A_TBL = 8'h18;
  localparam logic [AW-1:0] A_TBU = 8'h1c;
  localparam logic [2:0] SZ_WORD = 3'h2;
  localparam logic [27:0] CR1_PAD = 28'h0;

  // ------------------------------------------------------------
  // Carriers
  // ------------------------------------------------------------
  typedef struct packed {
    logic [0:5] primary;
    logic [0:4] d;
    logic [0:4] a;
    logic [0:4] b;
    logic [0:9] xop;
    logic record_flag;
  } instr_t;

  typedef struct packed {
    logic valid;
    instr_t instr;
    logic [0:63] fp_source_reg;
    logic [0:31] gp_source_reg;
  } issue_t;

  typedef struct packed {
    logic done;
    logic priv_exc;
    logic illegal_exc;
    logic sync_req;
    logic irq_take;
  } result_t;

endpackage

// ### hdl/status_special_reg_write.sv
/*
  Execution unit for status and special register writes: status bit
  set, masked and immediate status field writes, machine state word
  write and special register write, with an AHB-Lite slave that shows
  the state. Assumes the dispatch pipeline issues one op per cycle at
  most and takes the result one cycle later.
*/
`timescale 1ns/1ps
module status_special_reg_write
  import status_special_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  input wire issue_t issue,
  input wire logic ext_irq_pending,
  input wire logic dec_irq_pending,
  input wire logic higher_exc_pending,
  output result_t result,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp
);

  // ------------------------------------------------------------
  // Status word helpers
  // ------------------------------------------------------------
  function automatic logic [0:31] fix_sum(input logic [0:31] f);
    logic [0:31] r;
    r = f;
    r[VX] = (|f[VXB_LO:VXB_HI]) | (|f[VXE_LO:VXE_HI]);
    r[FP_ENABLED_SUMMARY] = |(r[EXB_LO:EXB_HI] & r[ENB_LO:ENB_HI]);
    return r;
  endfunction

  function automatic logic is_exc(input logic [0:4] idx);
    return ((idx >= 5'(EXC_LO)) && (idx <= 5'(EXC_HI))) ||
           ((idx >= 5'(VXE_LO)) && (idx <= 5'(VXE_HI)));
  endfunction

  function automatic logic [0:31] set_bit(input logic [0:31] f,
                                          input logic [0:4] idx);
    logic [0:31] r;
    r = f;
    if ((idx != 5'(FP_ENABLED_SUMMARY)) && (idx != 5'(VX))) begin
      r[idx] = 1'b1;
    end
    // Summary is set when an exception bit goes from zero to one.
    if (is_exc(idx) && !f[idx]) begin
      r[FX] = 1'b1;
    end
    return fix_sum(r);
  endfunction

  // Field 0 carries the summary and overflow bits straight from the
  // source; the two derived summaries are recomputed afterwards.
  function automatic logic [0:31] merge(input logic [0:31] f,
                                        input logic [0:31] s,
                                        input logic [0:7] m);
    logic [0:31] r;
    r = f;
    for (int i = 0; i < NFIELD; i++) begin
      if (m[i]) begin
        r[NIB*i +: NIB] = s[NIB*i +: NIB];
      end
    end
    return fix_sum(r);
  endfunction

  // ------------------------------------------------------------
  // State
  // ------------------------------------------------------------
  logic [0:31] float_status_control;
  logic [0:31] machine_state_word;
  logic [0:3] cr1;
  logic [0:31] fixed_point_exception_reg;
  logic [0:31] lr;
  logic [0:31] ctr;
  logic [63:0] tb;
  logic wr_pend;
  logic [AW-1:0] wr_addr;

  // ------------------------------------------------------------
  // Decode
  // ------------------------------------------------------------
  instr_t ins;
  logic v;
  logic user;
  logic is_fp;
  logic is_fsb1;
  logic is_fsf;
  logic is_fsfi;
  logic is_msr;
  logic is_spr;
  logic fp_op;
  logic [0:7] fm;
  logic [0:2] crf;
  logic [0:3] immediate_nibble;
  logic [0:7] fi_mask;
  logic [0:9] spr_num;
  logic spr_sup;
  logic spr_def;

  assign ins = issue.instr;
  assign v = issue.valid;
  assign user = machine_state_word[MSR_PR];
  assign is_fp = v && (ins.primary == OP_FP);
  assign is_fsb1 = is_fp && (ins.xop == XO_SET_BIT);
  assign is_fsf = is_fp && (ins.xop == XO_FIELDS);
  assign is_fsfi = is_fp && (ins.xop == XO_FIELD_IMM);
  assign is_msr = v && (ins.primary == OP_INT) && (ins.xop == XO_MSR);
  assign is_spr = v && (ins.primary == OP_INT) && (ins.xop == XO_SPR);
  assign fp_op = is_fsb1 || is_fsf || is_fsfi;
  assign fm = {ins.d[1:4], ins.a[0:3]};
  assign crf = ins.d[0:2];
  assign immediate_nibble = ins.b[0:3];
  assign fi_mask = 8'h80 >> crf;
  assign spr_num = {ins.b, ins.a}; // RULE13
  assign spr_sup = ins.a[0];
  assign spr_def = (spr_num == SPR_XER) || (spr_num == SPR_LR) ||
                   (spr_num == SPR_CTR) || (spr_num == SPR_TBL) ||
                   (spr_num == SPR_TBU);

  // ------------------------------------------------------------
  // Status word next value
  // ------------------------------------------------------------
  logic [0:31] fp_set;
  logic [0:31] fp_fsf;
  logic [0:31] fp_fsfi;
  logic [0:31] next_float_status_control;

  assign fp_set = set_bit(float_status_control, ins.d); // RULE1 RULE2 RULE3
  assign fp_fsf = merge(float_status_control, issue.fp_source_reg[32:63], fm); // RULE5 RULE6 RULE7 RULE8
  assign fp_fsfi = merge(float_status_control, {NFIELD{immediate_nibble}}, fi_mask); // RULE9 RULE7 RULE8
  assign next_float_status_control = is_fsb1 ? fp_set : (is_fsf ? fp_fsf : fp_fsfi);

  // ------------------------------------------------------------
  // Privilege and faults
  // ------------------------------------------------------------
  logic msr_ok;
  logic msr_priv;
  logic spr_priv;
  logic spr_ill;
  logic spr_ok;
  logic unknown;
  logic sync_need;
  logic irq_now;

  assign msr_priv = is_msr && user; // RULE10
  assign msr_ok = is_msr && !user;
  // Any privileged-bit number in user state faults as privileged,
  // defined or not, so the write never lands.
  assign spr_priv = is_spr && user && spr_sup; // RULE18 RULE19
  assign spr_ill = is_spr && !spr_def && !(user && spr_sup); // RULE15 RULE20
  assign spr_ok = is_spr && spr_def && !spr_priv; // RULE14 RULE16
  assign unknown = v && !fp_op && !is_msr && !is_spr;
  assign sync_need = msr_ok &&
    (|((machine_state_word ^ issue.gp_source_reg) & ~SYNC_FREE)); // RULE11
  assign irq_now = msr_ok && issue.gp_source_reg[MSR_EE] && !machine_state_word[MSR_EE] &&
    (ext_irq_pending || dec_irq_pending) && !higher_exc_pending; // RULE12

  // ------------------------------------------------------------
  // Bus decode
  // ------------------------------------------------------------
  logic go;
  logic bus_fp_wr;
  logic bus_msr_wr;
  logic [AW-1:0] ra;
  logic [31:0] rd_val;

  assign go = hsel && htrans[1] && hready && (hsize == SZ_WORD);
  assign bus_fp_wr = wr_pend && (wr_addr == A_FLOAT_STATUS_CONTROL);
  assign bus_msr_wr = wr_pend && (wr_addr == A_MSR);
  assign ra = haddr[AW-1:0];
  assign rd_val = (ra == A_FLOAT_STATUS_CONTROL) ? float_status_control :
                  (ra == A_MSR) ? machine_state_word :
                  (ra == A_CR1) ? {CR1_PAD, cr1} :
                  (ra == A_XER) ? fixed_point_exception_reg :
                  (ra == A_LR) ? lr :
                  (ra == A_CTR) ? ctr :
                  (ra == A_TBL) ? tb[31:0] :
                  (ra == A_TBU) ? tb[63:32] : WORD_RST;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  // ------------------------------------------------------------
  // Status word and condition field
  // ------------------------------------------------------------
  // An op write wins over a bus write landing in the same cycle.
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      float_status_control <= FLOAT_STATUS_CONTROL_RST;
    end else if (fp_op) begin
      float_status_control <= next_float_status_control;
    end else if (bus_fp_wr) begin
      float_status_control <= fix_sum(hwdata);
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      cr1 <= 4'h0;
    end else if (fp_op && ins.record_flag) begin
      cr1 <= next_float_status_control[FX:OX]; // RULE4 RULE21
    end
  end

  // ------------------------------------------------------------
  // Machine state word
  // ------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      machine_state_word <= MSR_RST;
    end else if (msr_ok) begin
      machine_state_word <= issue.gp_source_reg; // RULE10 RULE12
    end else if (bus_msr_wr) begin
      machine_state_word <= hwdata;
    end
  end

  // ------------------------------------------------------------
  // Special registers
  // ------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      fixed_point_exception_reg <= WORD_RST;
      lr <= WORD_RST;
      ctr <= WORD_RST;
    end else if (spr_ok) begin
      if (spr_num == SPR_XER) begin
        fixed_point_exception_reg <= issue.gp_source_reg; // RULE16
      end
      if (spr_num == SPR_LR) begin
        lr <= issue.gp_source_reg; // RULE16
      end
      if (spr_num == SPR_CTR) begin
        ctr <= issue.gp_source_reg; // RULE16
      end
    end
  end

  // The time base counts every clock; a half write suppresses the carry
  // across the halves for that cycle; the high half holds on a low write, the low half counts on during a high write.
  logic tbl_wr;
  logic tbu_wr;
  logic [63:0] tb_inc;

  assign tbl_wr = spr_ok && (spr_num == SPR_TBL);
  assign tbu_wr = spr_ok && (spr_num == SPR_TBU);
  assign tb_inc = tb + TB_ONE;

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      tb <= TB_RST;
    end else if (tbl_wr) begin
      tb <= {tb[63:32], issue.gp_source_reg}; // RULE17
    end else if (tbu_wr) begin
      tb <= {issue.gp_source_reg, tb_inc[31:0]}; // RULE17
    end else begin
      tb <= tb_inc;
    end
  end

  // ------------------------------------------------------------
  // Result to the completion pipeline
  // ------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      result <= '0;
    end else begin
      result.done <= v;
      result.priv_exc <= msr_priv || spr_priv; // RULE18
      result.illegal_exc <= spr_ill || unknown; // RULE20
      result.sync_req <= sync_need; // RULE11
      result.irq_take <= irq_now; // RULE12
    end
  end

  // ------------------------------------------------------------
  // Bus slave
  // ------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      wr_pend <= 1'b0;
      wr_addr <= '0;
      hrdata <= WORD_RST;
    end else begin
      wr_pend <= go && hwrite;
      wr_addr <= ra;
      if (go && !hwrite) begin
        hrdata <= rd_val;
      end
    end
  end

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  AST_SET_BIT: assert property ( // RULE1
    @(posedge clk) disable iff (!rst_b)
    (is_fsb1 && (ins.d != 5'(FP_ENABLED_SUMMARY)) && (ins.d != 5'(VX))) |=>
      float_status_control[$past(ins.d)])
    else $error("status bit not set");

  AST_SUMMARY_DERIVED: assert property ( // RULE2
    @(posedge clk) disable iff (!rst_b)
    $past(rst_b) |-> (float_status_control[VX] == ((|float_status_control[VXB_LO:VXB_HI]) |
      (|float_status_control[VXE_LO:VXE_HI]))) &&
      (float_status_control[FP_ENABLED_SUMMARY] == (|(float_status_control[EXB_LO:EXB_HI] & float_status_control[ENB_LO:ENB_HI]))))
    else $error("derived summary bits wrong");

  AST_FX_KEEP: assert property ( // RULE6
    @(posedge clk) disable iff (!rst_b)
    (is_fsf && !fm[0]) |=> $stable(float_status_control[FX]))
    else $error("summary changed without field 0");

  AST_FIELD0: assert property ( // RULE7
    @(posedge clk) disable iff (!rst_b)
    (is_fsf && fm[0]) |=>
      (float_status_control[FX] == $past(issue.fp_source_reg[32])) &&
      (float_status_control[OX] == $past(issue.fp_source_reg[35])))
    else $error("field 0 not copied from source");

  AST_FIELD_IMM: assert property ( // RULE9
    @(posedge clk) disable iff (!rst_b)
    (is_fsfi && (crf != 3'h0)) |=> (float_status_control[NIB*$past(crf) +: NIB] == $past(immediate_nibble)))
    else $error("immediate field not written");

  AST_CR1: assert property ( // RULE4
    @(posedge clk) disable iff (!rst_b)
    (fp_op && ins.record_flag) |=> (cr1 == float_status_control[FX:OX]))
    else $error("condition field one mismatch");

  AST_MSR_PRIV: assert property ( // RULE10
    @(posedge clk) disable iff (!rst_b)
    (msr_priv && !bus_msr_wr) |=> result.priv_exc && $stable(machine_state_word))
    else $error("user machine state write not refused");

  AST_LR_WRITE: assert property ( // RULE13
    @(posedge clk) disable iff (!rst_b)
    (is_spr && (ins.a == 5'h08) && (ins.b == 5'h00)) |=>
      (lr == $past(issue.gp_source_reg)))
    else $error("link register not written");

  AST_TB_HALF: assert property ( // RULE17
    @(posedge clk) disable iff (!rst_b)
    tbl_wr |=> (tb[63:32] == $past(tb[63:32])))
    else $error("high time base moved on low write");

  AST_SPR_PRIV: assert property ( // RULE18
    @(posedge clk) disable iff (!rst_b)
    (is_spr && user && spr_sup) |=> result.priv_exc && !result.illegal_exc)
    else $error("privileged fault missing");

  AST_IRQ: assert property ( // RULE12
    @(posedge clk) disable iff (!rst_b)
    result.irq_take |-> $past(msr_ok) && machine_state_word[MSR_EE] &&
      $past(ext_irq_pending || dec_irq_pending))
    else $error("interrupt taken without cause");

  AST_SPR_ILL: assert property ( // RULE20
    @(posedge clk) disable iff (!rst_b)
    (is_spr && !spr_def && !(user && spr_sup)) |=> result.illegal_exc && !result.priv_exc)
    else $error("undefined register number not refused");

  // Only the doze and byte order bits may change without asking for a sync.
  AST_SYNC_SKIP: assert property ( // RULE11
    @(posedge clk) disable iff (!rst_b)
    (msr_ok && (((machine_state_word ^ issue.gp_source_reg) & ~SYNC_FREE) == WORD_RST)) |=>
      !result.sync_req)
    else $error("sync asked for a sync-free change");

endmodule

// ### test/dispatch_model.sv
/*
  Behavioural dispatch and completion stage that feeds the status and
  special register write unit and catches its one-cycle result pulses.
  Assumes the bench raises send for one cycle for each op.
*/
`timescale 1ns/1ps
module dispatch_model
  import status_special_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic send,
  input wire issue_t op,
  input wire result_t result,
  output issue_t issue,
  output result_t seen
);
  // ----------------------------------------------------------------
  // Issue and completion
  // ----------------------------------------------------------------
  // Between ops the fields show the inverse of the last op, so a unit that
  // samples outside valid sees garbage rather than a lucky copy.
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      issue <= '0;
      seen <= '0;
    end else begin
      issue <= send ? op : ~op;
      seen <= result;
    end
  end
endmodule

// ### test/status_special_reg_write_tb_top.sv
/*
  Self-checking bench for the status and special register write unit.
  Assumes the dispatch model in its own file and an AHB-Lite view of all
  state, with hreadyout fed back as hready.
*/
`timescale 1ns/1ps
module status_special_reg_write_tb_top import status_special_pkg::*;;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic send = 1'b0;
  logic ext_p = 1'b0;
  logic dec_p = 1'b0;
  logic hi_p = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h0;
  logic [31:0] hwdata = 32'h0;
  logic hreadyout;
  logic [31:0] hrdata;
  logic hresp;
  issue_t op;
  issue_t issue;
  result_t result;
  result_t seen;
  int failures = 0;
  int n_compared = 0;
  logic [0:31] fs = 32'h0;
  logic [0:3] cr = 4'h0;

  always #2.5 clk = ~clk;

  status_special_reg_write u_dut (.clk(clk), .rst_b(rst_b), .issue(issue),
    .ext_irq_pending(ext_p), .dec_irq_pending(dec_p), .higher_exc_pending(hi_p),
    .result(result), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hrdata(hrdata), .hresp(hresp));
  dispatch_model u_disp (.clk(clk), .rst_b(rst_b), .send(send), .op(op),
    .result(result), .issue(issue), .seen(seen));

  // ----------------------------------------------------------------
  // Reporting and compares
  // ----------------------------------------------------------------
  task wrap_up;
    $display("compared %0d mismatches %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task chk32(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_compared++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task chk_res(input result_t got, input result_t exp);
    n_compared++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH t=%0t result got %b exp %b", $time, got, exp);
    end
  endtask

  task fail_out(input string what);
    failures++;
    $display("MISMATCH t=%0t %s timeout", $time, what);
    wrap_up();
  endtask

  // ----------------------------------------------------------------
  // Bus and issue drivers
  // ----------------------------------------------------------------
  task wait_rdy;
    int n;
    n = 0;
    @(posedge clk);
    while (hreadyout !== 1'b1) begin
      n++;
      if (n > 50) begin
        fail_out("bus ready");
      end
      @(posedge clk);
    end
  endtask

  task bus(input logic wr, input logic [7:0] a, input logic [31:0] wd,
           output logic [31:0] rd);
    @(posedge clk);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'b10;
    hwrite <= wr;
    hsize <= SZ_WORD;
    wait_rdy();
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    wait_rdy();
    rd = hrdata;
    chk32({31'h0, hresp}, 32'h0, "bus response");
  endtask

  task rd_chk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] v;
    bus(1'b0, a, 32'h0, v);
    chk32(v, exp, "bus read");
  endtask

  task run_op(input instr_t i, input logic [0:63] fp, input logic [0:31] gp,
              input result_t exp);
    int n;
    n = 0;
    @(posedge clk);
    op <= '{1'b1, i, fp, gp};
    send <= 1'b1;
    @(posedge clk);
    send <= 1'b0;
    #1;
    while (seen.done !== 1'b1) begin
      n++;
      if (n > 8) begin
        fail_out("op result");
      end
      @(posedge clk);
      #1;
    end
    chk_res(seen, exp);
  endtask

  function automatic instr_t mk(logic [0:5] p, logic [0:14] mid, logic [0:9] xo,
                                logic rc);
    return instr_t'({p, mid, xo, rc});
  endfunction

  // Expected status word: the two derived summaries are always recomputed from the bits.
  function automatic logic [0:31] derive(logic [0:31] s);
    s[VX] = (|s[VXB_LO:VXB_HI]) | (|s[VXE_LO:VXE_HI]);
    s[FP_ENABLED_SUMMARY] = |(s[EXB_LO:EXB_HI] & s[ENB_LO:ENB_HI]);
    return s;
  endfunction

  function automatic logic [0:31] fields(logic [0:31] s, logic [0:31] src,
                                         logic [0:7] fm);
    for (int i = 0; i < 8; i++) begin
      if (fm[i]) begin
        s[4*i +: 4] = src[4*i +: 4];
      end
    end
    return derive(s);
  endfunction

  // Condition field one only follows the status word on record forms.
  task chk_fs(input logic rc);
    if (rc) cr = fs[0:3];
    rd_chk(A_FLOAT_STATUS_CONTROL, fs);
    rd_chk(A_CR1, {CR1_PAD, cr});
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task t_bus_reset;
    logic [7:0] a[7] = '{A_FLOAT_STATUS_CONTROL, A_MSR, A_CR1, A_XER, A_LR, A_CTR, 8'h40};
    logic [31:0] v;
    foreach (a[k]) rd_chk(a[k], 32'h0);
    bus(1'b1, A_CR1, 32'h0000_000f, v);
    rd_chk(A_CR1, 32'h0);
  endtask

  task t_set_bit;
    int b[4] = '{24, 7, 1, 2};
    foreach (b[k]) begin
      if (b[k] >= EXC_LO && b[k] <= EXC_HI && !fs[b[k]]) fs[FX] = 1'b1;
      if (b[k] != FP_ENABLED_SUMMARY && b[k] != VX) fs[b[k]] = 1'b1;
      fs = derive(fs);
      run_op(mk(OP_FP, {5'(b[k]), 10'h0}, XO_SET_BIT, 1'b1), 64'h0, 32'h0, 5'b10000);
      chk_fs(1'b1);
    end
  endtask

  task t_fields;
    logic [0:7] fm[2] = '{8'h01, 8'hc0};
    logic [0:31] src[2] = '{32'h0000_000f, 32'hf000_0000};
    foreach (fm[k]) begin
      fs = fields(fs, src[k], fm[k]);
      run_op(mk(OP_FP, {1'b0, fm[k], 6'h0}, XO_FIELDS, 1'b1),
             {32'hffff_ffff, src[k]}, 32'h0, 5'b10000);
      chk_fs(1'b1);
    end
    for (int k = 0; k < 8; k++) begin
      fs = fields(fs, {8{4'(k + 3)}}, 8'h80 >> k);
      run_op(mk(OP_FP, {3'(k), 7'h0, 4'(k + 3), 1'b0}, XO_FIELD_IMM, k != 0),
             64'h0, 32'h0, 5'b10000);
      chk_fs(k != 0);
    end
  endtask

  task t_msr;
    logic [0:31] g[7] = '{32'h0000_8000, 32'h0, 32'h0000_8000, 32'h0, 32'h0000_8000,
                          32'h0004_8001, 32'h0000_4000};
    logic [0:6] e = 7'b1100000;
    logic [0:6] d = 7'b0011100;
    logic [0:6] h = 7'b0010000;
    logic [4:0] x[7] = '{5'b10011, 5'b10010, 5'b10010, 5'b10010, 5'b10011, 5'b10000,
                        5'b10010};
    foreach (g[k]) begin
      @(posedge clk);
      ext_p <= e[k];
      dec_p <= d[k];
      hi_p <= h[k];
      run_op(mk(OP_INT, 15'h0, XO_MSR, 1'b0), 64'h0, g[k], x[k]);
      rd_chk(A_MSR, g[k]);
    end
    run_op(mk(OP_INT, 15'h0, XO_MSR, 1'b0), 64'h0, 32'h0, 5'b11000);
    rd_chk(A_MSR, 32'h0000_4000);
  endtask

  task t_spr;
    logic [9:0] n[6] = '{10'd1, 10'd8, 10'd9, 10'd284, 10'd16, 10'd2};
    logic [7:0] a[3] = '{A_XER, A_LR, A_CTR};
    logic [4:0] x[6] = '{5'b10000, 5'b10000, 5'b10000, 5'b11000, 5'b11000, 5'b10100};
    logic [31:0] v;
    foreach (n[k]) begin
      run_op(mk(OP_INT, {5'h0, n[k][4:0], n[k][9:5]}, XO_SPR, 1'b0), 64'h0,
             32'h1357_9bd0 + k, x[k]);
      if (k < 3) rd_chk(a[k], 32'h1357_9bd0 + k);
    end
    rd_chk(A_XER, 32'h1357_9bd0);
    run_op(mk(6'h00, 15'h0, 10'h0, 1'b0), 64'h0, 32'h0, 5'b10100);
    bus(1'b1, A_MSR, 32'h0, v);
    run_op(mk(OP_INT, {10'h0, 5'b01000}, XO_SPR, 1'b0), 64'h0, 32'h5,
           5'b10100);
    rd_chk(A_LR, 32'h1357_9bd1);
    run_op(mk(OP_INT, {5'h0, 5'b11100, 5'b01000}, XO_SPR, 1'b0), 64'h0, 32'h0,
           5'b10000);
    rd_chk(A_TBU, 32'h0);
    run_op(mk(OP_INT, {5'h0, 5'b11101, 5'b01000}, XO_SPR, 1'b0), 64'h0, 32'h5,
           5'b10000);
    rd_chk(A_TBU, 32'h5);
    run_op(mk(OP_INT, {5'h0, 5'b11100, 5'b01000}, XO_SPR, 1'b0), 64'h0, 32'h0,
           5'b10000);
    rd_chk(A_TBU, 32'h5);
    bus(1'b0, A_TBL, 32'h0, v);
    chk32({31'h0, v < 32'h40}, 32'h1, "time low restart");
    run_op(mk(OP_INT, {5'h0, 5'b00010, 5'b00000}, XO_SPR, 1'b0), 64'h0, 32'h0,
           5'b10100);
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    op = '0;
    op.valid = 1'b1;
    repeat (20) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    t_bus_reset();
    t_set_bit();
    t_fields();
    t_msr();
    t_spr();
    wrap_up();
  end
endmodule
